/* File: rtl/wdlpw_pkg.sv */
// constants shared by the watchdog and low-power wake logic
`default_nettype none
package wdlpw_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] WD_CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] WD_KEY_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] WD_COUNT_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] POWER_CTRL0_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] WAKE_SELECT_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] POWER_STATE_OFS = 8'h1C;
    localparam int CTRL_DISABLE_BIT = 0;
    localparam int CTRL_WAKE_MODE_BIT = 1;
    localparam int CTRL_NMI_EN_BIT = 2;
    localparam int CTRL_W = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h4;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 2;
    localparam int QUAL_LSB = 2;
    localparam int QUAL_W = 6;
    localparam logic [7:0] POWER_CTRL0_RESET = 8'h0C;
    localparam int WAKE_W = 16;
    localparam logic [WAKE_W-1:0] WAKE_SELECT_RESET = 16'h0000;
    localparam int IRQ_W = 2;
    localparam int IRQ_OVERFLOW_BIT = 0;
    localparam int IRQ_WAKE_BIT = 1;
    localparam int WD_W = 8;
    localparam logic [WD_W-1:0] WD_MAX = 8'hFF;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam int PULSE_W = 10;
    localparam logic [PULSE_W-1:0] WD_PULSE_CYCLES = 10'h200;
    localparam int SYNC_W = 16;
    typedef enum logic [1:0] {
        WDLPW_RUN,
        WDLPW_IDLE,
        WDLPW_STANDBY,
        WDLPW_HALT
    } wdlpw_state_type;
endpackage
`default_nettype wire

/* File: rtl/wdlpw_key_detect.sv */
// two-write key sequence detector for the watchdog kick
`default_nettype none
module wdlpw_key_detect (
    input wire logic clk,
    input wire logic rstn,
    input wire logic key_wr,
    input wire logic [7:0] key_data,
    output logic kick
);
    import wdlpw_pkg::*;

    logic armed_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            armed_reg <= 1'b0;
        end else if (key_wr) begin
            // any write other than the first key disarms
            armed_reg <= (key_data == KEY_FIRST);
        end
    end

    // second key counts only straight after the first
    assign kick = key_wr && armed_reg && (key_data == KEY_SECOND);
endmodule
`default_nettype wire

/* File: rtl/wdlpw_wake_qual.sv */
// standby wake qualifier: selected low source must persist
`default_nettype none
module wdlpw_wake_qual (
    input wire logic clk,
    input wire logic rstn,
    input wire logic active,
    input wire logic [wdlpw_pkg::WAKE_W-1:0] sources_n,
    input wire logic [wdlpw_pkg::WAKE_W-1:0] select,
    input wire logic [wdlpw_pkg::QUAL_W-1:0] qual_len,
    output logic wake
);
    import wdlpw_pkg::*;

    logic [QUAL_W-1:0] cnt_reg;
    logic any_low;

    assign any_low = |(~sources_n & select);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= '0;
        end else if (!active || !any_low) begin
            // short glitch restarts qualification
            cnt_reg <= '0;
        end else if (cnt_reg < qual_len) begin
            cnt_reg <= cnt_reg + 6'h01;
        end
    end

    assign wake = active && any_low && (cnt_reg >= qual_len);
endmodule
`default_nettype wire

/* File: rtl/wdlpw_top.sv */
// watchdog counter with low-power mode controller and wishbone registers
`default_nettype none
// Summary of operation
// - 8-bit up counter pulses an output when it hits its maximum with no pulse running.
// - writing 0x55 then 0xAA to the key register clears the counter.
// - software may disable the counter; no overflow pulse while disabled.
// - overflow drives the active-low reset output low for 512 clocks.
// - watchdog interrupt signal feeds the standby wake logic when enabled.
// - in idle the watchdog interrupt reaches the core, ending idle.
// - standby stops peripherals; only the watchdog keeps counting.
// - idle instruction enters the selected mode; field 00 means idle.
// - idle keeps oscillator and peripheral clocks running, core clock off; exits on enabled interrupt or NMI.
// - field 01 selects standby, core clocks off, listed wake sources.
// - wake select register chooses which signals may end standby.
// - selected standby wake is qualified for a programmed clock count.
// - field 1x selects halt; all clocks stop, watchdog frozen.
// - halt is left only on external reset or the NMI input.
// - an enable bit gates the NMI input toward the core.
// - wake signals are active low; a short one falls back asleep.
// - standby and halt leave the system clock output in its prior state.
// - idle keeps the system clock output toggling.
module wdlpw_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [wdlpw_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [wdlpw_pkg::DATA_W-1:0] wb_dat_i,
    output logic [wdlpw_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic idle_exec,
    input wire logic core_irq_pending,
    input wire logic ext_sys_reset_n,
    input wire logic ext_nmi_n,
    input wire logic ext_irq1_n,
    input wire logic [3:0] timer_trip_inputs,
    input wire logic [5:0] compare_trip_inputs,
    input wire logic serial_a_rx,
    input wire logic serial_b_rx,
    input wire logic can_rx_wake,
    output logic wd_reset_out_n,
    output logic wd_wake_irq_n,
    output logic wd_irq_to_core,
    output logic nmi_to_core,
    output logic osc_clock_en,
    output logic core_clock_en,
    output logic periph_clock_en,
    output logic system_clock_out,
    output logic [1:0] power_state,
    output logic irq
);
    import wdlpw_pkg::*;

    wdlpw_state_type state_reg;
    wdlpw_state_type state_next;
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [CTRL_W-1:0] ctrl_reg;
    logic [7:0] power_ctrl_reg0;
    logic [WAKE_W-1:0] wake_select_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [WD_W-1:0] wd_count_reg;
    logic [PULSE_W-1:0] pulse_cnt_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic ack_reg;
    logic sysclk_reg;
    logic bus_req;
    logic wr_en;
    logic rd_en;
    logic key_wr;
    logic kick;
    logic wd_running;
    logic wd_overflow;
    logic pulse_active;
    logic wd_irq_n;
    logic rst_pin_low;
    logic nmi_pin_low;
    logic nmi_enabled;
    logic idle_exit;
    logic standby_wake;
    logic halt_exit;
    logic woke;
    logic [MODE_W-1:0] mode_field;
    logic [QUAL_W-1:0] qual_len;
    logic [WAKE_W-1:0] wake_sources_n;
    logic [IRQ_W-1:0] irq_events;
    logic [DATA_W-1:0] ctrl_merged;
    logic [DATA_W-1:0] pctrl_merged;
    logic [DATA_W-1:0] wsel_merged;

    // lane-aware merge of a write into the low bytes of a register
    function automatic logic [DATA_W-1:0] merge_lanes(
        input logic [DATA_W-1:0] old_val,
        input logic [DATA_W-1:0] new_val,
        input logic [3:0] sel
    );
        logic [DATA_W-1:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // pins from outside the clock domain
    assign pins_raw = {
        can_rx_wake,
        serial_b_rx,
        serial_a_rx,
        compare_trip_inputs,
        timer_trip_inputs,
        ext_nmi_n,
        ext_irq1_n,
        ext_sys_reset_n
    };

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end

    assign rst_pin_low = !sync2_reg[0];
    assign nmi_pin_low = !sync2_reg[2];
    assign nmi_enabled = ctrl_reg[CTRL_NMI_EN_BIT];

    // wake vector: bit0 watchdog, then pins without external reset
    assign wake_sources_n = {sync2_reg[SYNC_W-1:1], wd_irq_n};

    // wishbone classic slave, one wait state
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
    // write lands on the edge that carries ack, as the master sees it
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
    assign rd_en = bus_req && !wb_we_i;
    assign key_wr = wr_en && wb_sel_i[0] && (wb_adr_i == WD_KEY_OFS);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
        end
    end

    assign ctrl_merged = merge_lanes({29'h0, ctrl_reg}, wb_dat_i, wb_sel_i);
    assign pctrl_merged = merge_lanes({24'h0, power_ctrl_reg0}, wb_dat_i,
        wb_sel_i);
    assign wsel_merged = merge_lanes({16'h0, wake_select_reg}, wb_dat_i,
        wb_sel_i);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_en && wb_adr_i == WD_CTRL_OFS) begin
            ctrl_reg <= ctrl_merged[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            power_ctrl_reg0 <= POWER_CTRL0_RESET;
        end else if (wr_en && wb_adr_i == POWER_CTRL0_OFS) begin
            power_ctrl_reg0 <= pctrl_merged[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wake_select_reg <= WAKE_SELECT_RESET;
        end else if (wr_en && wb_adr_i == WAKE_SELECT_OFS) begin
            wake_select_reg <= wsel_merged[WAKE_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_mask_reg <= '0;
        end else if (wr_en && wb_adr_i == IRQ_MASK_OFS && wb_sel_i[0]) begin
            irq_mask_reg <= wb_dat_i[IRQ_W-1:0];
        end
    end

    assign mode_field = power_ctrl_reg0[MODE_LSB +: MODE_W];
    assign qual_len = power_ctrl_reg0[QUAL_LSB +: QUAL_W];

    // sticky status; a new event beats a write-one clear
    assign irq_events = {woke, wd_overflow};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_status_reg <= '0;
        end else if (wr_en && wb_adr_i == IRQ_STATUS_OFS && wb_sel_i[0]) begin
            irq_status_reg <= (irq_status_reg & ~wb_dat_i[IRQ_W-1:0])
                | irq_events;
        end else begin
            irq_status_reg <= irq_status_reg | irq_events;
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= '0;
        end else if (rd_en) begin
            case (wb_adr_i)
                WD_CTRL_OFS: rdata_reg <= {29'h0, ctrl_reg};
                WD_COUNT_OFS: rdata_reg <= {24'h0, wd_count_reg};
                POWER_CTRL0_OFS: rdata_reg <= {24'h0, power_ctrl_reg0};
                WAKE_SELECT_OFS: rdata_reg <= {16'h0, wake_select_reg};
                IRQ_STATUS_OFS: rdata_reg <= {30'h0, irq_status_reg};
                IRQ_MASK_OFS: rdata_reg <= {30'h0, irq_mask_reg};
                POWER_STATE_OFS: rdata_reg <= {29'h0, pulse_active,
                    state_reg};
                default: rdata_reg <= '0;
            endcase
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    wdlpw_key_detect u_key (
        .clk(clk),
        .rstn(rstn),
        .key_wr(key_wr),
        .key_data(wb_dat_i[7:0]),
        .kick(kick)
    );

    // halt stops the oscillator, so the watchdog freezes there
    assign wd_running = !ctrl_reg[CTRL_DISABLE_BIT]
        && state_reg != WDLPW_HALT;
    assign wd_overflow = wd_running && wd_count_reg == WD_MAX;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wd_count_reg <= '0;
        end else if (kick) begin
            wd_count_reg <= '0;
        end else if (wd_running) begin
            wd_count_reg <= wd_count_reg + 8'h01;
        end
    end

    // a second overflow during the pulse does not stretch it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_cnt_reg <= '0;
        end else if (wd_overflow && pulse_cnt_reg == '0) begin
            pulse_cnt_reg <= WD_PULSE_CYCLES;
        end else if (pulse_cnt_reg != '0 && state_reg != WDLPW_HALT) begin
            pulse_cnt_reg <= pulse_cnt_reg - 10'h001;
        end
    end

    assign pulse_active = pulse_cnt_reg != '0;
    // wake mode routes the pulse to the interrupt instead of reset
    assign wd_reset_out_n = !(pulse_active
        && !ctrl_reg[CTRL_WAKE_MODE_BIT]);
    assign wd_irq_n = !(pulse_active && ctrl_reg[CTRL_WAKE_MODE_BIT]);
    assign wd_wake_irq_n = wd_irq_n;
    assign wd_irq_to_core = !wd_irq_n;
    assign nmi_to_core = nmi_pin_low && nmi_enabled;

    wdlpw_wake_qual u_qual (
        .clk(clk),
        .rstn(rstn),
        .active(state_reg == WDLPW_STANDBY),
        .sources_n(wake_sources_n),
        .select(wake_select_reg),
        .qual_len(qual_len),
        .wake(standby_wake)
    );

    // idle exit; controller itself does nothing else in idle
    assign idle_exit = core_irq_pending || nmi_to_core || !wd_irq_n
        || rst_pin_low;
    assign halt_exit = rst_pin_low || nmi_pin_low;
    assign woke = state_reg != WDLPW_RUN && state_next == WDLPW_RUN;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            WDLPW_RUN: begin
                if (idle_exec) begin
                    if (mode_field[1]) begin
                        state_next = WDLPW_HALT;
                    end else if (mode_field[0]) begin
                        state_next = WDLPW_STANDBY;
                    end else begin
                        state_next = WDLPW_IDLE;
                    end
                end
            end
            WDLPW_IDLE: begin
                if (idle_exit) begin
                    state_next = WDLPW_RUN;
                end
            end
            WDLPW_STANDBY: begin
                if (rst_pin_low || standby_wake) begin
                    state_next = WDLPW_RUN;
                end
            end
            WDLPW_HALT: begin
                if (halt_exit) begin
                    state_next = WDLPW_RUN;
                end
            end
            default: begin
                state_next = WDLPW_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= WDLPW_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // clock gates only; pins are owned by peripherals, never reset here
    assign osc_clock_en = state_reg != WDLPW_HALT;
    assign core_clock_en = state_reg == WDLPW_RUN;
    assign periph_clock_en = state_reg == WDLPW_RUN
        || state_reg == WDLPW_IDLE;
    assign power_state = state_reg;

    // divided clock keeps running through idle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sysclk_reg <= 1'b0;
        end else if (periph_clock_en) begin
            sysclk_reg <= !sysclk_reg;
        end
    end

    assign system_clock_out = sysclk_reg;
endmodule
`default_nettype wire

/* File: dv/wdlpw_core_model.sv */
// processor core stand-in: idle instruction and pending interrupt
`default_nettype none
module wdlpw_core_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic go_idle,
    input wire logic raise_irq,
    input wire logic [1:0] power_state,
    output logic idle_exec,
    output logic core_irq_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    // the idle instruction only issues while the core runs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) idle_exec <= 1'h0;
        else idle_exec <= go_idle && power_state == 2'h0;
    end
    // pending stays up until the core runs again and takes it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) core_irq_pending <= 1'h0;
        else if (raise_irq) core_irq_pending <= 1'h1;
        else if (power_state == 2'h0) core_irq_pending <= 1'h0;
    end
endmodule
`default_nettype wire

/* File: dv/wdlpw_props.sv */
// assertions on the watchdog and power mode ports
`default_nettype none
module wdlpw_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ext_nmi_n,
    input wire logic wd_reset_out_n,
    input wire logic wd_wake_irq_n,
    input wire logic wd_irq_to_core,
    input wire logic nmi_to_core,
    input wire logic osc_clock_en,
    input wire logic core_clock_en,
    input wire logic periph_clock_en,
    input wire logic system_clock_out,
    input wire logic [1:0] power_state
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [9:0] low_reg;
    // frozen in halt, so only clocked cycles count
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) low_reg <= 10'h000;
        else if (wd_reset_out_n) low_reg <= 10'h000;
        else if (osc_clock_en) low_reg <= low_reg + 10'h001;
    end
    sequence pulse_end;
        $rose(wd_reset_out_n);
    endsequence
    sequence halt_nmi;
        power_state == 2'h3 && !ext_nmi_n;
    endsequence
    a_pulse_width: assert property (pulse_end |-> low_reg == 10'h200)
        else $error("reset pulse width wrong");
    a_halt_clocks: assert property (power_state == 2'h3 |->
        !osc_clock_en && !core_clock_en && !periph_clock_en)
        else $error("clock running in halt");
    a_idle_clocks: assert property (power_state == 2'h1 |->
        osc_clock_en && !core_clock_en && periph_clock_en)
        else $error("idle clocks wrong");
    a_standby_clocks: assert property (power_state == 2'h2 |->
        osc_clock_en && !core_clock_en && !periph_clock_en)
        else $error("standby clocks wrong");
    a_idle_sysclk: assert property (power_state == 2'h1 &&
        $past(power_state) == 2'h1 |->
        system_clock_out != $past(system_clock_out))
        else $error("system clock stopped in idle");
    a_halt_frozen: assert property (power_state == 2'h3 &&
        $past(power_state) == 2'h3 |-> $stable(system_clock_out))
        else $error("system clock moved in halt");
    a_halt_nmi_wake: assert property (halt_nmi |->
        ##[1:5] power_state == 2'h0)
        else $error("halt not left on nmi");
    a_nmi_gate: assert property (nmi_to_core |->
        !$past(ext_nmi_n, 2))
        else $error("nmi to core without pin");
    a_wake_link: assert property (wd_irq_to_core == !wd_wake_irq_n
        && (wd_wake_irq_n || wd_reset_out_n))
        else $error("wake pulse routing wrong");
endmodule
bind wdlpw_top wdlpw_props u_props (
    .clk(clk),
    .rstn(rstn),
    .ext_nmi_n(ext_nmi_n),
    .wd_reset_out_n(wd_reset_out_n),
    .wd_wake_irq_n(wd_wake_irq_n),
    .wd_irq_to_core(wd_irq_to_core),
    .nmi_to_core(nmi_to_core),
    .osc_clock_en(osc_clock_en),
    .core_clock_en(core_clock_en),
    .periph_clock_en(periph_clock_en),
    .system_clock_out(system_clock_out),
    .power_state(power_state)
);
`default_nettype wire

/* File: dv/wdlpw_top_tb.sv */
// register level tests of the watchdog and power mode block
`default_nettype none
module wdlpw_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wdlpw_pkg::*;
    logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0;
    logic go_idle = 0, raise_irq = 0, nmi_n = 1, srst_n = 1;
    logic irq1_n = 1, sera = 1;
    logic [7:0] adr = 0;
    logic [3:0] sel = 0;
    logic [31:0] dat = 0, q, c, dat_o;
    logic ack, idle_exec, pend, rst_o, wake_n, wirq, nmi_c, irq;
    logic osc_en, core_en, per_en, sclk;
    logic [1:0] pst;
    int n_errors = 0, comparisons = 0, i, n;
    always #10 clk = ~clk;
    wdlpw_top dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .idle_exec(idle_exec), .core_irq_pending(pend),
        .ext_sys_reset_n(srst_n), .ext_nmi_n(nmi_n),
        .ext_irq1_n(irq1_n), .timer_trip_inputs(4'hF),
        .compare_trip_inputs(6'h3F), .serial_a_rx(sera),
        .serial_b_rx(1'h1), .can_rx_wake(1'h1),
        .wd_reset_out_n(rst_o), .wd_wake_irq_n(wake_n),
        .wd_irq_to_core(wirq), .nmi_to_core(nmi_c),
        .osc_clock_en(osc_en), .core_clock_en(core_en),
        .periph_clock_en(per_en), .system_clock_out(sclk),
        .power_state(pst), .irq(irq));
    wdlpw_core_model core (.clk(clk), .rstn(rstn), .go_idle(go_idle),
        .raise_irq(raise_irq), .power_state(pst),
        .idle_exec(idle_exec), .core_irq_pending(pend));
    task close_out;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // held until the ack edge; read data taken at that edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do @(posedge clk); while (ack !== 1'h1);
        q = dat_o;
        cyc <= 0;
        stb <= 0;
        we <= 0;
        // idle cycle: a write that landed at the ack edge settles first
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(0, a, 0);
        chk(nm, q, e);
    endtask
    task kick;
        wb(1, WD_KEY_OFS, 32'h55);
        wb(1, WD_KEY_OFS, 32'hAA);
    endtask
    task st(input logic [1:0] s);
        for (int j = 0; j < 40 && pst !== s; j++) @(posedge clk);
        chk("state", pst, s);
    endtask
    task sleep;
        @(posedge clk) go_idle <= 1;
        @(posedge clk) go_idle <= 0;
    endtask
    initial begin
        #400000;
        n_errors++;
        close_out;
    end
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1;
        rd(WD_CTRL_OFS, {29'h0, CTRL_RESET}, "ctrl");
        rd(POWER_CTRL0_OFS, {24'h0, POWER_CTRL0_RESET}, "pctrl0");
        rd(WAKE_SELECT_OFS, 32'h0, "wake_sel");
        rd(8'h20, 32'h0, "unmapped");
        $display("test reset values done");
        kick;
        wb(0, WD_COUNT_OFS, 0);
        chk("count after kick", q < 8, 1);
        repeat (100) @(posedge clk);
        wb(1, WD_KEY_OFS, 32'h55);
        wb(1, WD_KEY_OFS, 32'h77);
        wb(1, WD_KEY_OFS, 32'hAA);
        wb(0, WD_COUNT_OFS, 0);
        chk("count after bad key", q >= 100, 1);
        $display("test key done");
        for (i = 0; i < 600 && rst_o !== 1'h1; i++) @(posedge clk);
        kick;
        // low cycles counted edge by edge from the fall
        for (i = 0; i < 400 && rst_o === 1'h1; i++) @(posedge clk);
        n = 0;
        while (rst_o === 1'h0 && n < 600) begin
            @(posedge clk);
            n++;
        end
        chk("pulse length", n, 512);
        wb(1, WD_CTRL_OFS, 32'h5);
        rd(IRQ_STATUS_OFS, 32'h1, "status overflow");
        wb(1, IRQ_MASK_OFS, 32'h1);
        chk("irq masked in", irq, 1);
        wb(1, IRQ_STATUS_OFS, 32'h1);
        chk("irq cleared", irq, 0);
        wb(0, WD_COUNT_OFS, 0);
        c = q;
        repeat (300) @(posedge clk);
        chk("no pulse disabled", rst_o, 1);
        rd(WD_COUNT_OFS, c, "count frozen");
        $display("test overflow done");
        wb(1, WD_CTRL_OFS, 32'h6);
        kick;
        sleep;
        st(1);
        for (i = 0; i < 400 && wirq !== 1'h1; i++) @(posedge clk);
        chk("wake irq", wirq, 1);
        chk("no reset in wake mode", rst_o, 1);
        st(0);
        // let the wake pulse end before leaving wake mode
        for (i = 0; i < 600 && wirq !== 1'h0; i++) @(posedge clk);
        wb(1, WD_CTRL_OFS, 32'h5);
        sleep;
        st(1);
        repeat (20) @(posedge clk);
        chk("idle holds", pst, 1);
        @(posedge clk) raise_irq <= 1;
        @(posedge clk) raise_irq <= 0;
        st(0);
        $display("test idle done");
        wb(1, IRQ_STATUS_OFS, 32'h3);
        wb(1, POWER_CTRL0_OFS, 32'h11);
        wb(1, WAKE_SELECT_OFS, 32'h2);
        sleep;
        st(2);
        @(posedge clk) irq1_n <= 0;
        @(posedge clk) irq1_n <= 1;
        repeat (10) @(posedge clk);
        chk("short wake", pst, 2);
        @(posedge clk) sera <= 0;
        repeat (20) @(posedge clk);
        sera <= 1;
        chk("unselected wake", pst, 2);
        @(posedge clk) irq1_n <= 0;
        repeat (3) @(posedge clk);
        chk("qualifying", pst, 2);
        st(0);
        irq1_n <= 1;
        rd(IRQ_STATUS_OFS, 32'h2, "status woke");
        $display("test standby done");
        for (i = 0; i < 2; i++) begin
            wb(1, POWER_CTRL0_OFS, 32'h12);
            sleep;
            st(3);
            repeat (20) @(posedge clk);
            chk("halt holds", pst, 3);
            @(posedge clk);
            if (i == 0) nmi_n <= 0;
            else srst_n <= 0;
            st(0);
            nmi_n <= 1;
            srst_n <= 1;
        end
        $display("test halt done");
        close_out;
    end
endmodule
`default_nettype wire
